//--- bau_byte_adder.sv
// eight-bit adder with carry in, carries out of bits three and seven, signed overflow
`timescale 1ns/1ps
module bau_byte_adder (
    input  wire logic               carry_in,
    input  wire bau_pkg::bau_byte_type opnd_a,
    input  wire bau_pkg::bau_byte_type opnd_b,
    output bau_pkg::bau_byte_type   sum,
    output logic                    carry_out,
    output logic                    half_out,
    output logic                    ovf_out
);
    import bau_pkg::*;

    logic [BAU_DATA_W:0] full_sum;
    logic [BAU_NIB_W:0]  low_sum;

    assign full_sum  = {1'b0, opnd_a} + {1'b0, opnd_b} + {{BAU_DATA_W{1'b0}}, carry_in};
    assign low_sum   = {1'b0, opnd_a[BAU_NIB_W-1:0]} + {1'b0, opnd_b[BAU_NIB_W-1:0]}
                     + {{BAU_NIB_W{1'b0}}, carry_in};
    assign sum       = full_sum[BAU_DATA_W-1:0];
    assign carry_out = full_sum[BAU_DATA_W];
    assign half_out  = low_sum[BAU_NIB_W];
    // like-signed operands giving an opposite-signed sum
    assign ovf_out   = (opnd_a[BAU_MSB] == opnd_b[BAU_MSB]) && (sum[BAU_MSB] != opnd_a[BAU_MSB]);
endmodule

//--- bau_pkg.sv
// constants, operation codes and register map of the byte arithmetic unit
// How it works
// - add immediate: work register plus immediate into work register, four flags updated
// - add memory: work register plus memory byte into register or memory
// - add with carry: register, memory byte and carry summed into chosen destination
// - carry added to work register, result kept there, four flags updated
// - carry added to memory byte, result written back, four flags updated
// - memory byte minus work register lands in work register, flags updated
// - work register minus memory byte written back to memory, flags updated
// - work register minus immediate via two's complement into work register
// - work register minus memory byte kept in work register, flags updated
// - memory byte minus work register written back to memory, flags updated
// - work register minus memory byte minus carry into work register
// - memory byte minus work register minus carry written back to memory
// - carry subtracted from work register, result kept there, flags updated
// - carry subtracted from memory byte, result written back, flags updated
// - increment adds one to memory byte, writes back, four flags updated
// - decrement subtracts one from memory byte, writes back, flags updated
// - clear writes zero into memory byte, all four flags untouched
package bau_pkg;
    localparam int BAU_DATA_W    = 8;
    localparam int BAU_ADDR_W    = 8;
    localparam int BAU_REG_AW    = 2;
    localparam int BAU_NIB_W     = 4;

    typedef logic [BAU_DATA_W-1:0] bau_byte_type;
    typedef logic [BAU_ADDR_W-1:0] bau_addr_type;
    typedef logic [BAU_REG_AW-1:0] bau_reg_addr_type;

    localparam bau_byte_type     BAU_BYTE_ZERO = 8'h00;
    localparam bau_byte_type     BAU_BYTE_ONE  = 8'h01;
    localparam bau_byte_type     BAU_BYTE_ONES = 8'hFF;
    localparam bau_addr_type     BAU_ADDR_ZERO = 8'h00;
    localparam logic [4:0]       BAU_NIB_MAX   = 5'h0F;

    // register port map
    localparam bau_reg_addr_type BAU_REG_WORK  = 2'h0;
    localparam bau_reg_addr_type BAU_REG_FLAGS = 2'h1;

    // bit positions inside the flags register
    localparam int BAU_FLAG_ZERO  = 0;
    localparam int BAU_FLAG_CARRY = 1;
    localparam int BAU_FLAG_HALF  = 2;
    localparam int BAU_FLAG_RANGE = 3;
    localparam int BAU_MSB        = 7;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_ADD_AI,
        OP_ADD_AM,
        OP_ADD_MA,
        OP_ADDC_AM,
        OP_ADDC_MA,
        OP_ADDC_A,
        OP_ADDC_M,
        OP_NADD_AM,
        OP_NADD_MA,
        OP_SUB_AI,
        OP_SUB_AM,
        OP_SUB_MA,
        OP_SUBC_AM,
        OP_SUBC_MA,
        OP_SUBC_A,
        OP_SUBC_M,
        OP_INC_M,
        OP_DEC_M,
        OP_CLEAR_M
    } bau_op_type;
endpackage

//--- bau_ram_model.sv
// data RAM behind the arithmetic unit, read combinationally, written on mem_we
`timescale 1ns/1ps
module bau_ram_model (
    input  wire logic                  clk,
    input  wire bau_pkg::bau_addr_type mem_addr,
    output bau_pkg::bau_byte_type      mem_rdata,
    input  wire logic                  mem_we,
    input  wire bau_pkg::bau_addr_type mem_waddr,
    input  wire bau_pkg::bau_byte_type mem_wdata
);
    import bau_pkg::*;

    bau_byte_type mem [0:255];

    // the unit does not forward, so a byte written this cycle is passed straight through
    assign mem_rdata = (mem_we && (mem_waddr == mem_addr)) ? mem_wdata : mem[mem_addr];

    always @(posedge clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end
endmodule

//--- byte_arithmetic_unit.sv
// arithmetic datapath: work register, flags and memory write-back of the core
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module byte_arithmetic_unit (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     op_valid,
    input  wire bau_pkg::bau_op_type      op_code,
    input  wire bau_pkg::bau_byte_type    imm_data,
    input  wire bau_pkg::bau_byte_type    mem_rdata,
    input  wire bau_pkg::bau_addr_type    mem_addr,
    input  wire bau_pkg::bau_reg_addr_type reg_addr,
    input  wire bau_pkg::bau_byte_type    reg_wdata,
    input  wire logic                     reg_we,
    input  wire logic                     reg_re,
    output bau_pkg::bau_byte_type         reg_rdata,
    output bau_pkg::bau_byte_type         work_register,
    output logic                          zero_flag,
    output logic                          carry_flag,
    output logic                          half_byte_flag,
    output logic                          signed_range_flag,
    output logic                          mem_we,
    output bau_pkg::bau_addr_type         mem_waddr,
    output bau_pkg::bau_byte_type         mem_wdata,
    output logic                          op_done
);
    import bau_pkg::*;

    // operations whose result goes back to the addressed memory byte
    function automatic logic op_writes_mem(input bau_op_type op);
        case (op)
            OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_NADD_MA, OP_SUB_MA,
            OP_SUBC_MA, OP_SUBC_M, OP_INC_M, OP_DEC_M, OP_CLEAR_M: op_writes_mem = 1'b1;
            default: op_writes_mem = 1'b0;
        endcase
    endfunction

    bau_byte_type work_register_r;
    bau_byte_type work_register_nxt;
    logic         zero_r;
    logic         zero_nxt;
    logic         carry_r;
    logic         carry_nxt;
    logic         half_r;
    logic         half_nxt;
    logic         range_r;
    logic         range_nxt;
    logic         mem_we_r;
    logic         mem_we_nxt;
    bau_addr_type mem_waddr_r;
    bau_addr_type mem_waddr_nxt;
    bau_byte_type mem_wdata_r;
    bau_byte_type mem_wdata_nxt;
    logic         op_done_r;
    logic         op_done_nxt;
    bau_byte_type reg_rdata_r;
    bau_byte_type reg_rdata_nxt;

    bau_byte_type sel_a;
    bau_byte_type sel_b;
    logic         use_carry;
    logic         is_sub;
    logic         known_op;
    logic         clear_op;
    logic         adder_cin;
    bau_byte_type adder_b;
    bau_byte_type adder_sum;
    logic         adder_cout;
    logic         adder_half;
    logic         adder_ovf;
    bau_byte_type result;

    // operand steering; subtraction inverts the second operand and feeds carry in
    always_comb begin
        sel_a     = work_register_r;
        sel_b     = BAU_BYTE_ZERO;
        use_carry = 1'b0;
        is_sub    = 1'b0;
        known_op  = 1'b1;
        clear_op  = 1'b0;
        case (op_code)
            OP_ADD_AI: begin
                sel_b = imm_data;
            end
            OP_ADD_AM, OP_ADD_MA: begin
                sel_b = mem_rdata;
            end
            OP_ADDC_AM, OP_ADDC_MA: begin
                sel_b     = mem_rdata;
                use_carry = 1'b1;
            end
            OP_ADDC_A: begin
                use_carry = 1'b1;
            end
            OP_ADDC_M: begin
                sel_a     = mem_rdata;
                use_carry = 1'b1;
            end
            OP_NADD_AM: begin
                sel_a  = mem_rdata;
                sel_b  = work_register_r;
                is_sub = 1'b1;
            end
            OP_NADD_MA: begin
                sel_b  = mem_rdata;
                is_sub = 1'b1;
            end
            OP_SUB_AI: begin
                sel_b  = imm_data;
                is_sub = 1'b1;
            end
            OP_SUB_AM: begin
                sel_b  = mem_rdata;
                is_sub = 1'b1;
            end
            OP_SUB_MA: begin
                sel_a  = mem_rdata;
                sel_b  = work_register_r;
                is_sub = 1'b1;
            end
            OP_SUBC_AM: begin
                sel_b     = mem_rdata;
                is_sub    = 1'b1;
                use_carry = 1'b1;
            end
            OP_SUBC_MA: begin
                sel_a     = mem_rdata;
                sel_b     = work_register_r;
                is_sub    = 1'b1;
                use_carry = 1'b1;
            end
            OP_SUBC_A: begin
                is_sub    = 1'b1;
                use_carry = 1'b1;
            end
            OP_SUBC_M: begin
                sel_a     = mem_rdata;
                is_sub    = 1'b1;
                use_carry = 1'b1;
            end
            OP_INC_M: begin
                sel_a = mem_rdata;
                sel_b = BAU_BYTE_ONE;
            end
            OP_DEC_M: begin
                sel_a  = mem_rdata;
                sel_b  = BAU_BYTE_ONE;
                is_sub = 1'b1;
            end
            OP_CLEAR_M: begin
                clear_op = 1'b1;
            end
            default: begin
                known_op = 1'b0;
            end
        endcase
        // borrow-style carry: a stored 1 means borrow, so the adder takes its inverse
        if (use_carry) begin
            adder_cin = is_sub ? ~carry_r : carry_r;
        end else begin
            adder_cin = is_sub;
        end
        adder_b = is_sub ? ~sel_b : sel_b;
    end

    bau_byte_adder u_adder (
        .carry_in  (adder_cin),
        .opnd_a    (sel_a),
        .opnd_b    (adder_b),
        .sum       (adder_sum),
        .carry_out (adder_cout),
        .half_out  (adder_half),
        .ovf_out   (adder_ovf)
    );

    // an instruction in the same cycle as a register write wins, the write is dropped
    always_comb begin
        work_register_nxt = work_register_r;
        zero_nxt          = zero_r;
        carry_nxt         = carry_r;
        half_nxt          = half_r;
        range_nxt         = range_r;
        mem_we_nxt        = 1'b0;
        mem_waddr_nxt     = mem_waddr_r;
        mem_wdata_nxt     = mem_wdata_r;
        op_done_nxt       = 1'b0;
        reg_rdata_nxt     = BAU_BYTE_ZERO;
        result            = clear_op ? BAU_BYTE_ZERO : adder_sum;
        if (reg_re) begin
            case (reg_addr)
                BAU_REG_WORK:  reg_rdata_nxt = work_register_r;
                BAU_REG_FLAGS: begin
                    reg_rdata_nxt[BAU_FLAG_ZERO]  = zero_r;
                    reg_rdata_nxt[BAU_FLAG_CARRY] = carry_r;
                    reg_rdata_nxt[BAU_FLAG_HALF]  = half_r;
                    reg_rdata_nxt[BAU_FLAG_RANGE] = range_r;
                end
                default: reg_rdata_nxt = BAU_BYTE_ZERO;
            endcase
        end
        if (reg_we) begin
            case (reg_addr)
                BAU_REG_WORK:  work_register_nxt = reg_wdata;
                BAU_REG_FLAGS: begin
                    zero_nxt  = reg_wdata[BAU_FLAG_ZERO];
                    carry_nxt = reg_wdata[BAU_FLAG_CARRY];
                    half_nxt  = reg_wdata[BAU_FLAG_HALF];
                    range_nxt = reg_wdata[BAU_FLAG_RANGE];
                end
                default: work_register_nxt = work_register_r;
            endcase
        end
        if (op_valid && known_op) begin
            op_done_nxt = 1'b1;
            if (op_writes_mem(op_code)) begin
                mem_we_nxt    = 1'b1;
                mem_waddr_nxt = mem_addr;
                mem_wdata_nxt = result;
                work_register_nxt = work_register_r;
            end else begin
                work_register_nxt = result;
            end
            if (clear_op) begin
                zero_nxt  = zero_r;
                carry_nxt = carry_r;
                half_nxt  = half_r;
                range_nxt = range_r;
            end else begin
                zero_nxt  = (result == BAU_BYTE_ZERO);
                range_nxt = adder_ovf;
                carry_nxt = is_sub ? ~adder_cout : adder_cout;
                half_nxt  = is_sub ? ~adder_half : adder_half;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            work_register_r <= BAU_BYTE_ZERO;
            zero_r          <= 1'b0;
            carry_r         <= 1'b0;
            half_r          <= 1'b0;
            range_r         <= 1'b0;
            mem_we_r        <= 1'b0;
            mem_waddr_r     <= BAU_ADDR_ZERO;
            mem_wdata_r     <= BAU_BYTE_ZERO;
            op_done_r       <= 1'b0;
            reg_rdata_r     <= BAU_BYTE_ZERO;
        end else begin
            work_register_r <= work_register_nxt;
            zero_r          <= zero_nxt;
            carry_r         <= carry_nxt;
            half_r          <= half_nxt;
            range_r         <= range_nxt;
            mem_we_r        <= mem_we_nxt;
            mem_waddr_r     <= mem_waddr_nxt;
            mem_wdata_r     <= mem_wdata_nxt;
            op_done_r       <= op_done_nxt;
            reg_rdata_r     <= reg_rdata_nxt;
        end
    end

    assign work_register     = work_register_r;
    assign zero_flag         = zero_r;
    assign carry_flag        = carry_r;
    assign half_byte_flag    = half_r;
    assign signed_range_flag = range_r;
    assign mem_we            = mem_we_r;
    assign mem_waddr         = mem_waddr_r;
    assign mem_wdata         = mem_wdata_r;
    assign op_done           = op_done_r;
    assign reg_rdata         = reg_rdata_r;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_ADD_IMM: assert property (op_valid && op_code == OP_ADD_AI |=>
        {carry_flag, work_register} == {1'b0, $past(work_register)} + $past(imm_data))
        else $error("add immediate result or carry wrong");
    AST_ADD_TO_MEM: assert property (op_valid && op_code == OP_ADD_MA |=>
        mem_we && mem_waddr == $past(mem_addr) && $stable(work_register)
        && mem_wdata == 8'($past(work_register) + $past(mem_rdata)))
        else $error("add to memory wrong");
    AST_ADDC_TO_WORK: assert property (op_valid && op_code == OP_ADDC_AM |=>
        !mem_we && work_register ==
        8'($past(work_register) + $past(mem_rdata) + $past(carry_flag)))
        else $error("add with carry into work register wrong");
    AST_ADDC_WORK: assert property (op_valid && op_code == OP_ADDC_A |=>
        work_register == 8'($past(work_register) + $past(carry_flag)))
        else $error("carry add on work register wrong");
    AST_ADDC_MEM: assert property (op_valid && op_code == OP_ADDC_M |=>
        mem_we && mem_wdata == 8'($past(mem_rdata) + $past(carry_flag)))
        else $error("carry add on memory wrong");
    AST_NADD_WORK: assert property (op_valid && op_code == OP_NADD_AM |=>
        work_register == 8'($past(mem_rdata) - $past(work_register)))
        else $error("reverse subtract into work register wrong");
    AST_NADD_MEM: assert property (op_valid && op_code == OP_NADD_MA |=>
        mem_we && mem_wdata == 8'($past(work_register) - $past(mem_rdata)))
        else $error("reverse subtract into memory wrong");
    AST_SUB_IMM: assert property (op_valid && op_code == OP_SUB_AI |=>
        work_register == 8'($past(work_register) - $past(imm_data))
        && carry_flag == ($past(work_register) < $past(imm_data)))
        else $error("subtract immediate result or borrow wrong");
    AST_SUB_WORK: assert property (op_valid && op_code == OP_SUB_AM |=>
        work_register == 8'($past(work_register) - $past(mem_rdata)))
        else $error("subtract into work register wrong");
    AST_SUB_MEM: assert property (op_valid && op_code == OP_SUB_MA |=>
        mem_we && mem_wdata == 8'($past(mem_rdata) - $past(work_register)))
        else $error("subtract into memory wrong");
    AST_SUBC_WORK: assert property (op_valid && op_code == OP_SUBC_AM |=>
        work_register ==
        8'($past(work_register) - $past(mem_rdata) - $past(carry_flag)))
        else $error("subtract with borrow into work register wrong");
    AST_SUBC_MEM: assert property (op_valid && op_code == OP_SUBC_MA |=>
        mem_we && mem_wdata ==
        8'($past(mem_rdata) - $past(work_register) - $past(carry_flag)))
        else $error("subtract with borrow into memory wrong");
    AST_SUBC_A: assert property (op_valid && op_code == OP_SUBC_A |=>
        work_register == 8'($past(work_register) - $past(carry_flag)))
        else $error("borrow subtract on work register wrong");
    AST_SUBC_M: assert property (op_valid && op_code == OP_SUBC_M |=>
        mem_we && mem_wdata == 8'($past(mem_rdata) - $past(carry_flag)))
        else $error("borrow subtract on memory wrong");
    AST_INC: assert property (op_valid && op_code == OP_INC_M |=>
        mem_we && mem_wdata == 8'($past(mem_rdata) + BAU_BYTE_ONE)
        && carry_flag == ($past(mem_rdata) == BAU_BYTE_ONES))
        else $error("increment wrong");
    AST_DEC: assert property (op_valid && op_code == OP_DEC_M |=>
        mem_we && mem_wdata == 8'($past(mem_rdata) - BAU_BYTE_ONE)
        && carry_flag == ($past(mem_rdata) == BAU_BYTE_ZERO))
        else $error("decrement wrong");
    AST_CLEAR: assert property (op_valid && op_code == OP_CLEAR_M |=>
        mem_we && mem_wdata == BAU_BYTE_ZERO && $stable(zero_flag) && $stable(carry_flag)
        && $stable(half_byte_flag) && $stable(signed_range_flag))
        else $error("clear changed flags or wrote nonzero");
    AST_ZERO_FLAG: assert property (op_done && $past(op_code) != OP_CLEAR_M |->
        zero_flag == ((op_writes_mem($past(op_code)) ? mem_wdata : work_register)
        == BAU_BYTE_ZERO))
        else $error("zero flag does not match stored result");
    AST_ADD_RANGE: assert property (op_valid && op_code == OP_ADD_AM |=>
        signed_range_flag == ($past(work_register[BAU_MSB]) == $past(mem_rdata[BAU_MSB])
        && work_register[BAU_MSB] != $past(work_register[BAU_MSB])))
        else $error("signed range flag wrong on add");
    AST_HALF_ADD: assert property (op_valid && op_code == OP_ADD_AM |=>
        half_byte_flag == ((5'($past(work_register[3:0])) + 5'($past(mem_rdata[3:0])))
        > BAU_NIB_MAX))
        else $error("half byte carry wrong on add");
endmodule

//--- byte_arithmetic_unit_test.sv
// self-checking bench for the byte arithmetic unit with a reference computation
`timescale 1ns/1ps
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (act), (exp)); end end
module byte_arithmetic_unit_test;
    import bau_pkg::*;
    typedef struct {
        logic         tm;
        bau_addr_type a;
        bau_byte_type r;
        bau_byte_type w;
        logic [3:0]   f;
    } bau_note_type;
    logic             clk, sys_rst, op_valid, reg_we, reg_re, re_d;
    logic             zero_flag, carry_flag, half_byte_flag, signed_range_flag, mem_we, op_done;
    bau_op_type       op_code;
    bau_addr_type     mem_addr, mem_waddr;
    bau_reg_addr_type reg_addr;
    bau_byte_type     imm_data, mem_rdata, reg_wdata, reg_rdata, work_register, mem_wdata;
    bau_byte_type     ew;
    logic             ez, ec, eh, eo;
    bau_byte_type     sh [0:255];
    bau_note_type     oq [$];
    bau_byte_type     rq [$];
    int               errors = 0;
    int               n_checks = 0;
    int               cyc = 0;
    integer           seed;
    bau_op_type   b_op [9] = '{OP_ADDC_A, OP_INC_M, OP_INC_M, OP_DEC_M, OP_DEC_M,
                               OP_SUBC_M, OP_SUB_AI, OP_ADD_AI, OP_CLEAR_M};
    bau_byte_type b_w  [9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h00};
    bau_byte_type b_f  [9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h0F};
    bau_byte_type b_m  [9] = '{8'h00, 8'h7F, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5A};

    byte_arithmetic_unit dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .imm_data(imm_data), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .work_register(work_register), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .half_byte_flag(half_byte_flag),
        .signed_range_flag(signed_range_flag), .mem_we(mem_we), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .op_done(op_done));
    bau_ram_model ram (.clk(clk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish;
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // every task except tally_and_finish drives all request inputs for exactly one cycle, so none is assigned twice
    task automatic drive(logic v, bau_op_type op, bau_addr_type a, bau_byte_type imm,
                         logic we, logic re, bau_reg_addr_type ra, bau_byte_type wd);
        op_valid  <= v;
        op_code   <= op;
        mem_addr  <= a;
        imm_data  <= imm;
        reg_we    <= we;
        reg_re    <= re;
        reg_addr  <= ra;
        reg_wdata <= wd;
        @(posedge clk);
    endtask

    task automatic idle;
        drive(1'h0, OP_NONE, 8'h00, 8'h00, 1'h0, 1'h0, BAU_REG_WORK, 8'h00);
    endtask

    task automatic wr(bau_reg_addr_type ra, bau_byte_type d);
        if (ra == BAU_REG_WORK) ew = d;
        if (ra == BAU_REG_FLAGS) {eo, eh, ec, ez} = d[3:0];
        drive(1'h0, OP_NONE, 8'h00, 8'h00, 1'h1, 1'h0, ra, d);
    endtask

    task automatic rd(bau_reg_addr_type ra);
        rq.push_back(ra == BAU_REG_WORK ? ew : ra == BAU_REG_FLAGS ? {4'h0, eo, eh, ec, ez} : 8'h00);
        drive(1'h0, OP_NONE, 8'h00, 8'h00, 1'h0, 1'h1, ra, 8'h00);
    endtask

    task automatic issue(bau_op_type op, bau_addr_type a, bau_byte_type imm);
        bau_byte_type m, x, y, r;
        logic         ci, sb, tm, h, o;
        logic [8:0]   s;
        m = sh[a];
        {x, y, ci, sb, tm} = {ew, m, 1'h0, 1'h0, 1'h0};
        case (op)
            OP_ADD_AI:  {x, y, ci, sb, tm} = {ew, imm, 1'h0, 1'h0, 1'h0};
            OP_ADD_MA:  {x, y, ci, sb, tm} = {ew, m, 1'h0, 1'h0, 1'h1};
            OP_ADDC_AM: {x, y, ci, sb, tm} = {ew, m, ec, 1'h0, 1'h0};
            OP_ADDC_MA: {x, y, ci, sb, tm} = {ew, m, ec, 1'h0, 1'h1};
            OP_ADDC_A:  {x, y, ci, sb, tm} = {ew, 8'h00, ec, 1'h0, 1'h0};
            OP_ADDC_M:  {x, y, ci, sb, tm} = {m, 8'h00, ec, 1'h0, 1'h1};
            OP_NADD_AM: {x, y, ci, sb, tm} = {m, ew, 1'h0, 1'h1, 1'h0};
            OP_NADD_MA: {x, y, ci, sb, tm} = {ew, m, 1'h0, 1'h1, 1'h1};
            OP_SUB_AI:  {x, y, ci, sb, tm} = {ew, imm, 1'h0, 1'h1, 1'h0};
            OP_SUB_AM:  {x, y, ci, sb, tm} = {ew, m, 1'h0, 1'h1, 1'h0};
            OP_SUB_MA:  {x, y, ci, sb, tm} = {m, ew, 1'h0, 1'h1, 1'h1};
            OP_SUBC_AM: {x, y, ci, sb, tm} = {ew, m, ec, 1'h1, 1'h0};
            OP_SUBC_MA: {x, y, ci, sb, tm} = {m, ew, ec, 1'h1, 1'h1};
            OP_SUBC_A:  {x, y, ci, sb, tm} = {ew, 8'h00, ec, 1'h1, 1'h0};
            OP_SUBC_M:  {x, y, ci, sb, tm} = {m, 8'h00, ec, 1'h1, 1'h1};
            OP_INC_M:   {x, y, ci, sb, tm} = {m, 8'h01, 1'h0, 1'h0, 1'h1};
            OP_DEC_M:   {x, y, ci, sb, tm} = {m, 8'h01, 1'h0, 1'h1, 1'h1};
            default:    {x, y, ci, sb, tm} = {ew, m, 1'h0, 1'h0, 1'h0};
        endcase
        if (sb) begin
            s = {1'h0, x} - {1'h0, y} - {8'h00, ci};
            h = {1'h0, x[3:0]} < ({1'h0, y[3:0]} + {4'h0, ci});
            o = (x[7] != y[7]) && (s[7] != x[7]);
        end else begin
            s = {1'h0, x} + {1'h0, y} + {8'h00, ci};
            h = ({1'h0, x[3:0]} + {1'h0, y[3:0]} + {4'h0, ci}) > 5'h0F;
            o = (x[7] == y[7]) && (s[7] != x[7]);
        end
        r = s[7:0];
        if (op == OP_CLEAR_M) begin
            r = 8'h00;
            tm = 1'h1;
        end else if (op != OP_NONE) begin
            {ec, eh, eo, ez} = {s[8], h, o, r == 8'h00};
        end
        if (tm) sh[a] = r;
        else if (op != OP_NONE) ew = r;
        if (op != OP_NONE) oq.push_back('{tm, a, r, ew, {eo, eh, ec, ez}});
        // a register write beside a real instruction must be lost
        drive(1'h1, op, a, imm, imm[0] && op != OP_NONE, 1'h0, imm[2:1], ~imm);
    endtask

    always @(posedge clk) begin
        bau_note_type n;
        if (!sys_rst) begin
            if (re_d) `CHK(reg_rdata, rq.pop_front())
            re_d <= reg_re;
            if (op_done === 1'h1) begin
                `CHK(oq.size() != 0, 1'h1)
                if (oq.size() != 0) begin
                    n = oq.pop_front();
                    `CHK(mem_we, n.tm)
                    `CHK(n.tm ? mem_waddr : n.a, n.a)
                    `CHK(n.tm ? mem_wdata : n.r, n.r)
                    `CHK(work_register, n.w)
                    `CHK({signed_range_flag, half_byte_flag, carry_flag, zero_flag}, n.f)
                end
            end
        end else begin
            re_d <= 1'h0;
        end
    end

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish;
        end
    end

    initial begin
        seed = 32'h00F7;
        {ew, ez, ec, eh, eo} = '0;
        {sys_rst, op_valid, reg_we, reg_re} = 4'h8;
        {op_code, imm_data, mem_addr, reg_addr, reg_wdata} = '0;
        for (int i = 0; i < 256; i++) begin
            sh[i] = 8'($random(seed));
            ram.mem[i] = sh[i];
        end
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        idle();
        for (int i = 0; i < 4; i++) rd(2'(i));
        wr(2'h2, 8'hA5);
        rd(2'h2);
        for (int k = 0; k < 20; k++) begin
            wr(BAU_REG_WORK, 8'($random(seed)));
            wr(BAU_REG_FLAGS, 8'($random(seed)));
            for (int o = 0; o <= int'(OP_CLEAR_M); o++) begin
                issue(bau_op_type'(o), 8'($random(seed) & 3), 8'($random(seed)));
            end
            rd(BAU_REG_WORK);
            rd(BAU_REG_FLAGS);
        end
        for (int i = 0; i < 9; i++) begin
            wr(BAU_REG_WORK, b_w[i]);
            wr(BAU_REG_FLAGS, b_f[i]);
            sh[8'h40] = b_m[i];
            ram.mem[8'h40] = b_m[i];
            issue(b_op[i], 8'h40, 8'h01);
            rd(BAU_REG_FLAGS);
        end
        repeat (3) idle();
        `CHK(oq.size() + rq.size(), 0)
        tally_and_finish();
    end
endmodule
